// [src/pca_pkg.sv]
package pca_pkg;
  // Bus clock figures
  localparam int CLK_PERIOD_NS   = 50;          // Local clock period
  localparam int PCI_FMAX_MHZ    = 33;          // Highest allowed bus clock
  // Target response timing
  localparam int DEVSEL_WAIT_CYC = 6;           // Master-abort window in clocks
  localparam int PERR_DELAY_CYC  = 2;           // Parity error lag behind AD
  // Reset values of pin drivers (active-low pins, released = 1)
  localparam logic PIN_IDLE      = 1'b1;        // Deasserted level
  localparam logic OE_OFF        = 1'b1;        // Enable high means not driving
  // Interrupt routing codes
  localparam logic [1:0] ROUTE_NONE = 2'h0;     // Source drives nothing
  localparam logic [1:0] ROUTE_A    = 2'h1;     // Source drives line A
  localparam logic [1:0] ROUTE_B    = 2'h2;     // Source drives line B
  // Bus commands that reach configuration space
  localparam logic [3:0] CMD_CFG_RD = 4'ha;     // Configuration read
  localparam logic [3:0] CMD_CFG_WR = 4'hb;     // Configuration write
  localparam int NUM_IRQ_SRC     = 4;           // Interrupt sources

  // Master sequencer states
  typedef enum logic [2:0] {
    PCA_M_IDLE, PCA_M_ADDR, PCA_M_DATA, PCA_M_TURN
  } pca_mst_e;
  // Target sequencer states
  typedef enum logic [1:0] {
    PCA_T_IDLE, PCA_T_SEL, PCA_T_DATA, PCA_T_TURN
  } pca_tgt_e;

  // Even parity over data and command lanes
  function automatic logic pca_par(input logic [31:0] ad, input logic [3:0] cbe);
    pca_par = ^{ad, cbe};
  endfunction
endpackage

// [src/pca_irq.sv]
// Interrupt status, masking and routing onto the two open-drain lines
module pca_irq
  import pca_pkg::*;
#(
  parameter int NSRC = NUM_IRQ_SRC              // Number of sources
) (
  input  wire logic            clk,             // Bus clock
  input  wire logic            rstn,            // Async reset, low
  input  wire logic            ce,              // Clock enable
  input  wire logic [NSRC-1:0] src_evt,         // Event pulses
  input  wire logic [NSRC-1:0] src_ack,         // Acknowledge pulses
  input  wire logic [NSRC-1:0] src_mask,        // 1 masks source
  input  wire logic [2*NSRC-1:0] src_route,     // Two routing bits per source
  output logic [NSRC-1:0]      stat,            // Sticky status
  output logic                 inta_oen,        // Line A enable, low drives
  output logic                 intb_oen         // Line B enable, low drives
);
  logic [NSRC-1:0] stat_r, stat_nxt;            // Status flags
  logic            a_r, a_nxt, b_r, b_nxt;      // Line request flops

  // Set beats acknowledge in the same cycle
  always_comb begin
    logic [1:0] rt;
    rt = ROUTE_NONE;
    stat_nxt = (stat_r & ~src_ack) | src_evt;
    a_nxt = 1'b0;
    b_nxt = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      rt = src_route[2*i +: 2];
      if (stat_nxt[i] && !src_mask[i] && rt == ROUTE_A) begin // see (RL17) (RL19)
        a_nxt = 1'b1;
      end
      if (stat_nxt[i] && !src_mask[i] && rt == ROUTE_B) begin // see (RL19)
        b_nxt = 1'b1;
      end
    end
  end

  // Each line drops only when no unmasked flag routed to it stays
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
      a_r    <= 1'b0;
      b_r    <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      a_r    <= a_nxt;                          // see (RL18)
      b_r    <= b_nxt;
    end
  end

  assign stat     = stat_r;
  assign inta_oen = ~a_r;                       // see (RL22)
  assign intb_oen = ~b_r;
endmodule

// [src/pca_ctrl.sv]
// Summary of operation
// (RL1) Data moves when both readies sampled low
// (RL2) Master ready only with data or space
// (RL3) Initiator ready: output as master, input target
// (RL4) Target ready only with data or space
// (RL5) Target ready: input as master, output target
// (RL6) Stop: target drives, master obeys; the master ends on stop here only in its final data phase (m_last high)
// (RL7) Everything sampled on rising clock edge
// (RL8) Config select answers device select next clock
// (RL9) No device select in six: abort, interrupt
// (RL10) Device select driven as target, sampled master
// (RL11) Parity error two clocks after lines
// (RL12) System error output on fatal error
// (RL13) Request asserted while bus wanted
// (RL14) Start only after grant and frame idle
// (RL15) One bus clock times all logic
// (RL16) Reset puts all pins to idle; req_n still follows m_start during reset
// (RL17) Interrupt A from unmasked active status
// (RL18) Interrupt A released after acknowledge only; masking or rerouting the source also releases it here
// (RL19) Each source routed to A, B, none
// (RL20) Even parity, one clock behind data
// (RL21) Frame held until final data phase
// (RL22) Open-drain outputs only pull low
// (RL23) Handshake lines released outside own role
module pca_ctrl
  import pca_pkg::*;
(
  input  wire logic        clk,                 // Bus clock, single domain (see RL15)
  input  wire logic        rstn,                // Async reset, low
  input  wire logic        ce,                  // Clock enable
  input  wire logic [31:0] ad_i,                // Address/data in
  input  wire logic [3:0]  cbe_n_i,             // Command/byte enable in
  input  wire logic        par_i,               // Parity in
  input  wire logic        frame_n_i,           // Frame in
  output logic             frame_n_o,           // Frame out
  output logic             frame_n_oe,          // Frame enable, low drives
  input  wire logic        irdy_n_i,            // Initiator ready in
  output logic             irdy_n_o,            // Initiator ready out
  output logic             irdy_n_oe,           // Enable, low drives
  input  wire logic        trdy_n_i,            // Target ready in
  output logic             trdy_n_o,            // Target ready out
  output logic             trdy_n_oe,           // Enable, low drives
  input  wire logic        stop_n_i,            // Stop in
  output logic             stop_n_o,            // Stop out
  output logic             stop_n_oe,           // Enable, low drives
  input  wire logic        devsel_n_i,          // Device select in
  output logic             devsel_n_o,          // Device select out
  output logic             devsel_n_oe,         // Enable, low drives
  input  wire logic        idsel,               // Config select, high
  output logic             perr_n_oe,           // Parity error, low pulls
  output logic             serr_n_oe,           // System error, low pulls
  output logic             req_n,               // Bus request
  input  wire logic        gnt_n,               // Bus grant
  output logic             inta_n_oe,           // Interrupt A, low pulls
  output logic             intb_n_oe,           // Interrupt B, low pulls
  input  wire logic        m_start,             // Master wants a transfer
  input  wire logic        m_write,             // Master direction
  input  wire logic        m_last,              // Final data phase
  input  wire logic        m_ready,             // Data or space available
  output logic             m_busy,              // Master transfer running
  output logic             m_beat,              // Master data phase done
  output logic             m_abort,             // Master abort pulse
  output logic             m_stopped,           // Ended by target stop
  input  wire logic        t_ready,             // Target data or space
  input  wire logic        t_stop,              // Target wants to stop
  output logic             t_cfg,               // Config access active
  output logic             t_beat,              // Target data phase done
  input  wire logic        fatal_err,           // Fatal error pulse
  input  wire logic [NUM_IRQ_SRC-1:0]   irq_ack,   // Status acknowledge
  input  wire logic [NUM_IRQ_SRC-1:0]   irq_mask,  // Source masks
  input  wire logic [2*NUM_IRQ_SRC-1:0] irq_route, // Source routing
  input  wire logic [NUM_IRQ_SRC-2:0]   irq_evt,   // Other event sources
  output logic [NUM_IRQ_SRC-1:0]        irq_stat   // Status flags
);
  // Master side state
  pca_mst_e   ms_r, ms_nxt;                     // Master sequencer
  logic [2:0] wait_r, wait_nxt;                 // Device select wait count
  logic       sel_seen_r, sel_seen_nxt;         // Target claimed transfer
  logic       abort_r, abort_nxt;               // Abort pulse flop
  logic       beat_r, beat_nxt;                 // Master beat flop
  logic       stp_r, stp_nxt;                   // Stopped flop
  // Target side state
  pca_tgt_e   ts_r, ts_nxt;                     // Target sequencer
  logic       tbeat_r, tbeat_nxt;               // Target beat flop
  // Parity pipeline
  logic [31:0] ad_q;                            // Lines one clock back
  logic [3:0]  cbe_q;                           // Command one clock back
  logic        chk_q, chk_nxt;                  // Check qualifier pipe
  logic        perr_r, perr_nxt;                // Parity error level
  logic        serr_r, serr_nxt;                // System error level
  logic        drv_q;                           // Lines driven by us last clock

  logic bus_idle;                               // Frame and initiator ready idle
  logic phase_done;                             // Both readies low
  logic cfg_hit;                                // Config address decode
  assign bus_idle   = frame_n_i && irdy_n_i;
  assign phase_done = !irdy_n_i && !trdy_n_i;   // see (RL1)
  assign cfg_hit    = idsel && (cbe_n_i == CMD_CFG_RD || cbe_n_i == CMD_CFG_WR); // see (RL8)

  // Master sequencer next state
  always_comb begin
    ms_nxt       = ms_r;
    wait_nxt     = wait_r;
    sel_seen_nxt = sel_seen_r;
    abort_nxt    = 1'b0;
    beat_nxt     = 1'b0;
    stp_nxt      = 1'b0;
    case (ms_r)
      PCA_M_IDLE: begin
        // Only start on grant once the last frame has gone
        if (m_start && !gnt_n && bus_idle && ts_r == PCA_T_IDLE) begin // see (RL14)
          ms_nxt       = PCA_M_ADDR;
          wait_nxt     = '0;
          sel_seen_nxt = 1'b0;
        end
      end
      PCA_M_ADDR: begin
        ms_nxt = PCA_M_DATA;
      end
      PCA_M_DATA: begin
        if (!devsel_n_i) begin                  // see (RL10)
          sel_seen_nxt = 1'b1;
        end
        if (!sel_seen_r && devsel_n_i) begin
          wait_nxt = wait_r + 3'h1;
        end
        // Nobody claimed the address: master abort
        if (!sel_seen_r && devsel_n_i && wait_r == 3'(DEVSEL_WAIT_CYC - 1)) begin // see (RL9)
          ms_nxt    = PCA_M_TURN;
          abort_nxt = 1'b1;
        end else if (phase_done) begin          // see (RL1)
          beat_nxt = 1'b1;
          if (frame_n_o) begin                  // see (RL21)
            ms_nxt = PCA_M_TURN;
          end
        end else if (!stop_n_i && frame_n_o) begin // see (RL6)
          ms_nxt  = PCA_M_TURN;
          stp_nxt = 1'b1;
        end
      end
      PCA_M_TURN: begin
        ms_nxt = PCA_M_IDLE;
      end
      default: ms_nxt = PCA_M_IDLE;
    endcase
  end

  // Target sequencer next state
  always_comb begin
    ts_nxt    = ts_r;
    tbeat_nxt = 1'b0;
    case (ts_r)
      PCA_T_IDLE: begin
        // Address phase: frame just fell
        if (!frame_n_i && irdy_n_i && ms_r == PCA_M_IDLE && cfg_hit) begin
          ts_nxt = PCA_T_SEL;
        end
      end
      PCA_T_SEL: begin
        ts_nxt = PCA_T_DATA;
      end
      PCA_T_DATA: begin
        if (phase_done) begin                   // see (RL1)
          tbeat_nxt = 1'b1;
          if (frame_n_i) begin                  // see (RL21)
            ts_nxt = PCA_T_TURN;
          end
        end else if (!stop_n_o && frame_n_i && !irdy_n_i) begin
          ts_nxt = PCA_T_TURN;
        end
      end
      PCA_T_TURN: begin
        ts_nxt = PCA_T_IDLE;
      end
      default: ts_nxt = PCA_T_IDLE;
    endcase
  end

  // Parity check and error flags
  always_comb begin
    // Check inbound phases only, never our own driven lines
    chk_nxt  = !frame_n_i || !irdy_n_i;
    perr_nxt = chk_q && !drv_q && (pca_par(ad_q, cbe_q) != par_i); // see (RL11) (RL20)
    serr_nxt = fatal_err;                       // see (RL12)
  end

  // Register all sequencer and error state
  always_ff @(posedge clk or negedge rstn) begin // see (RL7)
    if (!rstn) begin                            // see (RL16)
      ms_r       <= PCA_M_IDLE;
      wait_r     <= '0;
      sel_seen_r <= 1'b0;
      abort_r    <= 1'b0;
      beat_r     <= 1'b0;
      stp_r      <= 1'b0;
      ts_r       <= PCA_T_IDLE;
      tbeat_r    <= 1'b0;
      ad_q       <= '0;
      cbe_q      <= '0;
      chk_q      <= 1'b0;
      drv_q      <= 1'b0;
      perr_r     <= 1'b0;
      serr_r     <= 1'b0;
    end else if (ce) begin
      ms_r       <= ms_nxt;
      wait_r     <= wait_nxt;
      sel_seen_r <= sel_seen_nxt;
      abort_r    <= abort_nxt;
      beat_r     <= beat_nxt;
      stp_r      <= stp_nxt;
      ts_r       <= ts_nxt;
      tbeat_r    <= tbeat_nxt;
      ad_q       <= ad_i;
      cbe_q      <= cbe_n_i;
      chk_q      <= chk_nxt;
      drv_q      <= (ms_r == PCA_M_ADDR) || (ms_r == PCA_M_DATA && m_write);
      perr_r     <= perr_nxt;
      serr_r     <= serr_nxt;
    end
  end

  // Pin drivers: ownership follows the active role
  logic m_own, t_own;                           // Role owns handshake lines
  assign m_own = (ms_r == PCA_M_ADDR) || (ms_r == PCA_M_DATA) || (ms_r == PCA_M_TURN);
  assign t_own = (ts_r != PCA_T_IDLE);
  assign frame_n_o   = !(ms_r == PCA_M_ADDR || (ms_r == PCA_M_DATA && !m_last)); // see (RL21)
  assign frame_n_oe  = m_own ? 1'b0 : OE_OFF;
  assign irdy_n_o    = !(ms_r == PCA_M_DATA && m_ready);  // see (RL2) (RL3)
  assign irdy_n_oe   = m_own ? 1'b0 : OE_OFF;   // see (RL23)
  assign trdy_n_o    = !(ts_r == PCA_T_DATA && t_ready);  // see (RL4) (RL5)
  assign trdy_n_oe   = t_own ? 1'b0 : OE_OFF;   // see (RL23)
  assign stop_n_o    = !(ts_r == PCA_T_DATA && t_stop);   // see (RL6)
  assign stop_n_oe   = t_own ? 1'b0 : OE_OFF;
  assign devsel_n_o  = !(ts_r == PCA_T_SEL || ts_r == PCA_T_DATA); // see (RL8) (RL10)
  assign devsel_n_oe = t_own ? 1'b0 : OE_OFF;
  assign perr_n_oe   = ~perr_r;                 // see (RL22)
  assign serr_n_oe   = ~serr_r;                 // see (RL22)
  // Request held from wish until the master leaves idle
  assign req_n       = !(m_start && ms_r == PCA_M_IDLE); // see (RL13)
  assign m_busy      = ms_r != PCA_M_IDLE;
  assign m_beat      = beat_r;
  assign m_abort     = abort_r;
  assign m_stopped   = stp_r;
  assign t_cfg       = t_own;
  assign t_beat      = tbeat_r;

  // Abort is interrupt source 0
  pca_irq #(.NSRC(NUM_IRQ_SRC)) u_irq (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .src_evt  ({irq_evt, abort_r}),             // see (RL9)
    .src_ack  (irq_ack),
    .src_mask (irq_mask),
    .src_route(irq_route),
    .stat     (irq_stat),
    .inta_oen (inta_n_oe),                      // see (RL17)
    .intb_oen (intb_n_oe)
  );

  // Checks
  sequence s_addr_out;
    ms_r == PCA_M_ADDR;
  endsequence
  chk_abort_window: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL9)
    s_addr_out ##1 (devsel_n_i && ce) [*6] |=> m_abort)
    else $error("abort missing after six idle select clocks");
  chk_cfg_select: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL8)
    (ts_r == PCA_T_IDLE && ts_nxt == PCA_T_SEL) |=> !devsel_n_o && !devsel_n_oe)
    else $error("config select not answered next clock");
  chk_perr_lag: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL11)
    (chk_nxt && !drv_q && ms_r == PCA_M_IDLE && ts_r == PCA_T_IDLE) ##1 ce ##0
      (pca_par(ad_q, cbe_q) != par_i) |=> !perr_n_oe)
    else $error("parity error not flagged");
  chk_req_start: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL14)
    (ms_r == PCA_M_IDLE && ms_nxt == PCA_M_ADDR) |-> (!gnt_n && frame_n_i) ##1 (!frame_n_o && !frame_n_oe))
    else $error("start without grant or idle frame");
  chk_role_tri: assert property (@(posedge clk) disable iff (!rstn) // see (RL23)
    !m_own |-> irdy_n_oe && frame_n_oe)
    else $error("master lines driven when not master");
  chk_beat_done: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL1)
    (ms_r == PCA_M_DATA && phase_done && !(!sel_seen_r && devsel_n_i && wait_r == 3'(DEVSEL_WAIT_CYC - 1)))
      |=> m_beat)
    else $error("master beat lost");
  chk_serr_drive: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL12)
    fatal_err |=> !serr_n_oe)
    else $error("system error not driven");
  chk_reset_idle: assert property (@(posedge clk) // see (RL16)
    !rstn |-> trdy_n_oe && stop_n_oe && devsel_n_oe && perr_n_oe && req_n)
    else $error("pins not idle in reset");

  // Target stop with ready withheld on the final phase
  sequence s_tgt_stop;
    ts_r == PCA_T_DATA && !stop_n_o && trdy_n_o && frame_n_i && !irdy_n_i;
  endsequence
  // Turn cycle, then every target line released
  sequence s_tgt_leave;
    ts_r == PCA_T_TURN ##1 (ts_r == PCA_T_IDLE && devsel_n_oe && stop_n_oe && trdy_n_oe);
  endsequence
  // A stop must end the cycle without a phantom data beat
  chk_tgt_stop: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL6)
    s_tgt_stop |=> !t_beat ##0 s_tgt_leave)
    else $error("target stop did not end the cycle");

  // Claimed master cycle that the far target stops without data
  sequence s_mst_stop;
    ms_r == PCA_M_DATA && !devsel_n_i && !stop_n_i && trdy_n_i && frame_n_o;
  endsequence
  // Stop must win over a wait state, never count as a beat
  chk_mst_stop: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL6)
    s_mst_stop |=> m_stopped && !m_beat && ms_r == PCA_M_TURN)
    else $error("master ignored target stop");

  // Target lines left to other agents outside our target role
  chk_tgt_tri: assert property (@(posedge clk) disable iff (!rstn) // see (RL23)
    !t_own |-> trdy_n_oe && stop_n_oe && devsel_n_oe)
    else $error("target lines driven when not target");

  // Initiator ready tracks local readiness in every data clock
  chk_irdy_role: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL2)
    (ms_r == PCA_M_DATA) |-> !irdy_n_oe && (irdy_n_o == !m_ready))
    else $error("initiator ready not following readiness");

  // Request stands for as long as an idle master wants the bus
  chk_req_wish: assert property (@(posedge clk) disable iff (!rstn || !ce) // see (RL13)
    (ms_r == PCA_M_IDLE && m_start) |-> !req_n)
    else $error("bus request missing while wanted");
endmodule

// [test/pca_far_tgt.sv]
// Far-side target model: claims the device's master cycles on the shared bus
module pca_far_tgt (
  input  wire logic       clk,       // Bus clock
  input  wire logic       rstn,      // Async reset, low
  input  wire logic       en,        // Claim transactions when high
  input  wire logic [2:0] dly,       // Clocks before claiming
  input  wire logic       stop_req,  // Ask the initiator to stop
  input  wire logic       frame_n,   // Resolved frame
  input  wire logic       irdy_n,    // Resolved initiator ready
  output logic            oe_n,      // Low drives the three lines
  output logic            devsel_n,  // Select drive value
  output logic            trdy_n,    // Ready drive value
  output logic            stop_n     // Stop drive value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       act_r;                 // Transaction seen
  logic [2:0] cnt_r;                 // Clocks since frame seen

  // Everything moves on the rising edge, except the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_r    <= 1'b0;
      cnt_r    <= 3'h0;
      oe_n     <= 1'b1;
      devsel_n <= 1'b1;
      trdy_n   <= 1'b1;
      stop_n   <= 1'b1;
    end else if (!act_r) begin
      // A disabled model lets the device run into its abort
      if (!frame_n && en) begin
        act_r <= 1'b1;
        cnt_r <= 3'h1;
      end
    end else begin
      if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
      // Slow or prompt claim; a stop request withholds ready, so no data moves
      if (cnt_r >= dly) begin
        oe_n     <= 1'b0;
        devsel_n <= 1'b0;
        trdy_n   <= stop_req;
        stop_n   <= !stop_req;
      end
      // Final phase ends on data or on stop once frame is gone
      if (!oe_n && !irdy_n && (!trdy_n || !stop_n) && frame_n) begin
        act_r    <= 1'b0;
        oe_n     <= 1'b1;
        devsel_n <= 1'b1;
        trdy_n   <= 1'b1;
        stop_n   <= 1'b1;
      end
    end
  end
endmodule

// [test/tb.sv]
// Self-checking bench for the bus agent control block
module tb
  import pca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, ce, par_i, idsel, gnt_n, m_start, m_write, m_last, m_ready, t_ready, t_stop, fatal_err;
  logic [31:0] ad_i;                 // Address/data lines
  logic [3:0]  cbe_n_i, irq_ack, irq_mask, irq_stat;
  logic [7:0]  irq_route;            // Two bits a source
  logic [2:0]  irq_evt, p_dly;       // Event pulses, model delay
  logic frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, trdy_n_o, trdy_n_oe, stop_n_o, stop_n_oe;
  logic devsel_n_o, devsel_n_oe, perr_n_oe, serr_n_oe, req_n, inta_n_oe, intb_n_oe;
  logic m_busy, m_beat, m_abort, m_stopped, t_cfg, t_beat;
  logic h_oe_n, h_frame_n, h_irdy_n; // Bench acting as another initiator
  logic p_en, p_stop, p_oe_n, p_devsel_n, p_trdy_n, p_stop_n;
  wire  frame_n_i, irdy_n_i, trdy_n_i, stop_n_i, devsel_n_i;
  int   n_fail, checks_done, cycles;

  // Wired bus with pull-ups: released lines read high
  assign frame_n_i  = !frame_n_oe ? frame_n_o : (!h_oe_n ? h_frame_n : 1'b1);
  assign irdy_n_i   = !irdy_n_oe ? irdy_n_o : (!h_oe_n ? h_irdy_n : 1'b1);
  assign trdy_n_i   = !trdy_n_oe ? trdy_n_o : (!p_oe_n ? p_trdy_n : 1'b1);
  assign stop_n_i   = !stop_n_oe ? stop_n_o : (!p_oe_n ? p_stop_n : 1'b1);
  assign devsel_n_i = !devsel_n_oe ? devsel_n_o : (!p_oe_n ? p_devsel_n : 1'b1);

  pca_ctrl dut (.clk, .rstn, .ce, .ad_i, .cbe_n_i, .par_i, .frame_n_i, .frame_n_o, .frame_n_oe, .irdy_n_i,
    .irdy_n_o, .irdy_n_oe, .trdy_n_i, .trdy_n_o, .trdy_n_oe, .stop_n_i, .stop_n_o, .stop_n_oe, .devsel_n_i,
    .devsel_n_o, .devsel_n_oe, .idsel, .perr_n_oe, .serr_n_oe, .req_n, .gnt_n, .inta_n_oe, .intb_n_oe,
    .m_start, .m_write, .m_last, .m_ready, .m_busy, .m_beat, .m_abort, .m_stopped, .t_ready, .t_stop,
    .t_cfg, .t_beat, .fatal_err, .irq_ack, .irq_mask, .irq_route, .irq_evt, .irq_stat);

  pca_far_tgt far (.clk, .rstn, .en(p_en), .dly(p_dly), .stop_req(p_stop), .frame_n(frame_n_i),
    .irdy_n(irdy_n_i), .oe_n(p_oe_n), .devsel_n(p_devsel_n), .trdy_n(p_trdy_n), .stop_n(p_stop_n));

  // 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the hundred-odd cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs change only at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Master write; busy holds another frame first, stop has the target end it
  task automatic t_master(input logic busy, input logic stop);
    logic sb, ss;
    sb = 1'b0;
    ss = 1'b0;
    p_stop = stop;
    p_en = !busy;
    p_dly = busy ? 3'h4 : 3'h1;
    if (busy) begin
      h_oe_n = 1'b0;
      h_frame_n = 1'b0;
      cbe_n_i = 4'h6;
    end
    m_start = 1'b1;
    m_write = 1'b1;
    m_last = 1'b1;
    m_ready = 1'b1;
    gnt_n = 1'b0;
    #1 chk(req_n, 1'b0);
    if (busy) begin
      cyc(3);
      chk(frame_n_oe, 1'b1);
      h_oe_n = 1'b1;
      p_en = 1'b1;
    end
    cyc(1);
    chk({frame_n_oe, frame_n_o, m_busy}, 3'h1);
    m_start = 1'b0;
    repeat (12) begin
      cyc(1);
      sb = sb | m_beat;
      ss = ss | m_stopped;
    end
    chk(ss, stop);
    chk(sb, !stop);
    chk({frame_n_oe, irdy_n_oe, m_busy}, 3'h6);
    // Let an edge pass so the next call may grant again
    gnt_n = 1'b1;
    cyc(1);
  endtask

  // Host config or other cycle aimed at the device, optional bad address parity or target stop
  task automatic t_target(input logic [3:0] cmd, input logic bad, input logic stp);
    logic hit;
    hit = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
    p_en = 1'b0;
    h_oe_n = 1'b0;
    h_frame_n = 1'b0;
    h_irdy_n = 1'b1;
    idsel = 1'b1;
    cbe_n_i = cmd;
    ad_i = 32'h0000_1234;
    t_ready = !stp;
    t_stop = stp;
    cyc(1);
    par_i = ^{ad_i, cbe_n_i} ^ bad;
    ad_i = 32'h0;
    cbe_n_i = 4'h0;
    h_frame_n = 1'b1;
    h_irdy_n = 1'b0;
    cyc(1);
    par_i = 1'b0;
    chk(devsel_n_oe, !hit);
    if (hit) chk(devsel_n_o, 1'b0);
    chk(t_cfg, hit);
    chk(stop_n_o, !(hit && stp));
    // Error shows in the clock right after the parity clock
    chk(perr_n_oe, !bad);
    cyc(1);
    chk(perr_n_oe, 1'b1);
    for (int i = 0; i < 8 && t_beat !== 1'b1; i++) cyc(1);
    chk(t_beat, hit && !stp);
    h_irdy_n = 1'b1;
    h_oe_n = 1'b1;
    idsel = 1'b0;
    cyc(3);
    chk({devsel_n_oe, trdy_n_oe, stop_n_oe}, 3'h7);
  endtask

  // Unclaimed read: abort, then interrupt set, route, mask and acknowledge
  task automatic t_abort;
    int k;
    k = 0;
    p_en = 1'b0;
    irq_route = {4'h0, ROUTE_B, ROUTE_A};
    m_start = 1'b1;
    m_write = 1'b0;
    m_ready = 1'b0;
    gnt_n = 1'b0;
    cyc(1);
    m_start = 1'b0;
    cyc(1);
    chk({irdy_n_oe, irdy_n_o}, 2'h1);
    while (k < 14 && m_abort !== 1'b1) begin
      cyc(1);
      k++;
    end
    chk(k >= 5 && k <= 8, 1'b1);
    gnt_n = 1'b1;
    m_ready = 1'b1;
    cyc(2);
    chk({irq_stat[0], inta_n_oe, intb_n_oe}, 3'h5);
    irq_ack = 4'h1;
    cyc(1);
    irq_ack = 4'h0;
    cyc(2);
    chk({irq_stat[0], inta_n_oe}, 2'h1);
    irq_evt = 3'h1;
    cyc(1);
    irq_evt = 3'h0;
    cyc(2);
    chk({irq_stat[1], inta_n_oe, intb_n_oe}, 3'h6);
    irq_mask = 4'h2;
    cyc(2);
    chk(intb_n_oe, 1'b1);
    irq_ack = 4'h2;
    cyc(1);
    irq_ack = 4'h0;
    irq_mask = 4'h0;
  endtask

  // Fatal error shows on the next clock
  // Clock enable low first: the error must wait for it
  task automatic t_serr;
    chk(serr_n_oe, 1'b1);
    ce = 1'b0;
    fatal_err = 1'b1;
    cyc(1);
    chk(serr_n_oe, 1'b1);
    ce = 1'b1;
    cyc(1);
    fatal_err = 1'b0;
    chk(serr_n_oe, 1'b0);
  endtask

  initial begin
    {par_i, idsel, m_start, m_write, m_last, m_ready, t_ready, t_stop, fatal_err} = 9'h0;
    {rstn, gnt_n, h_oe_n, h_frame_n, h_irdy_n, ce} = 6'h3f;
    {p_en, p_stop, p_dly, ad_i, cbe_n_i} = 41'h0;
    {irq_ack, irq_mask, irq_route, irq_evt} = 19'h0;
    // Reset falls after start-up so every flop is sure to see it
    cyc(1);
    rstn = 1'b0;
    cyc(2);
    chk({frame_n_oe, irdy_n_oe, trdy_n_oe, stop_n_oe, devsel_n_oe, perr_n_oe, serr_n_oe, inta_n_oe,
         intb_n_oe, req_n}, 10'h3ff);
    cyc(3);
    rstn = 1'b1;
    cyc(1);
    t_master(1'b0, 1'b0);
    t_master(1'b1, 1'b0);
    t_master(1'b0, 1'b1);
    t_target(CMD_CFG_WR, 1'b0, 1'b0);
    t_target(CMD_CFG_RD, 1'b1, 1'b0);
    t_target(CMD_CFG_RD, 1'b0, 1'b1);
    t_target(4'h6, 1'b0, 1'b0);
    t_abort();
    t_serr();
    finish_test();
  end
endmodule
